// file: dltpc_deser_end.sv
`timescale 1ns/1ps
// Notes on behaviour
// - spread both clock and data when enabled
// - system picks range select by link clock
// - normal range spread setting decode table
// - low range spread setting decode table
// - power control low holds power-down
// - auto mode powers down on stream stop
// - idle select sets outputs during power-down
// - power-down resets the control registers
// - missing clock markers enter sleep
// - sleep keeps registers, relock on resume
// - self-test pattern sent and checked
// - serializer test enable precedes deserializer's
// - test pattern recognised disables parallel outputs
// - errored payload pulses pass low
// - test enable width sets duration, latch
// - result high when no errors seen
// - result held until test, reset, powerdown
// - both enables low restores normal traffic
// - checker compares payload bits only
// - bad marker bits drop the lock
// - lock low until acquisition completes
module dltpc_deser_end
   import dltpc_pkg::*;
(
   // clock and reset
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   // link side
   dltpc_link_if.des                 link,
   // straps
   input  wire logic [2:0]           spread_setting_strap,
   input  wire logic                 idle_select_strap,
   input  wire logic                 auto_detect_strap,
   // register port
   input  wire logic [7:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output logic      [7:0]           reg_rdata_q,
   // parallel outputs
   output logic      [PAYLOAD_W-1:0] data_out_q,
   output logic                      data_oe_q,
   output logic                      clk_out_en_q,
   output logic                      lock_q,
   output logic                      pass_q,
   // spread clock generator settings
   output logic                      spread_enable_q,
   output logic      [11:0]          spread_divisor_q,
   output logic      [4:0]           spread_dev_q
);
   // pin synchronisers: bit0 power_enable_n, bit1 self_test_enable, bit2 range select
   logic [2:0]   pin_s1_q;                 // first stage, read by second only
   logic [2:0]   pin_s2_q;
   logic [2:0]   pin_s3_q;
   logic [2:0]   pin_f_q;                  // filtered level
   logic [2:0]   pin_f_d;

   dltpc_state_t st_q;                     // link state
   dltpc_state_t st_d;
   logic [2:0]   good_cnt_q;               // consecutive good markers
   logic [3:0]   stop_cnt_q;               // consecutive empty frames
   logic [7:0]   ctrl_q;                   // control register
   logic [7:0]   errcnt_q;                 // errored payload count, saturating
   logic [6:0]   chk_state_q;              // checker prediction state
   logic         chk_sync_q;               // checker seeded
   logic         err_seen_q;               // an error in the current test
   logic         test_pin_d1_q;            // previous test enable level
   logic         checking_q;               // test running
   logic [PAYLOAD_W-1:0] expect_bits;
   logic [6:0]   chk_next;

   // decode
   wire          pd_pin     = ~pin_f_q[0];
   wire          test_pin   = pin_f_q[1];
   wire          lf_pin     = pin_f_q[2];
   wire          mark_good  = (link.marker == MARK_GOOD);
   wire          mark_none  = (link.marker == MARK_NONE);
   wire          stop_now   = mark_none && (stop_cnt_q == STOP_FRAMES - 4'h1);
   wire          locked     = (st_q == DS_LOCKED);
   wire          test_cmd   = locked && link.test_cmd;
   wire          test_start = test_pin && !test_pin_d1_q;
   wire          test_stop  = !test_pin && test_pin_d1_q;
   wire          check_on   = test_cmd && test_pin && checking_q;
   wire          mismatch   = |(link.payload ^ expect_bits);
   wire          reg_mode   = ctrl_q[CTRL_REG_MODE];
   wire [2:0]    spread_eff = reg_mode ? ctrl_q[CTRL_SPREAD_LSB +: 3] : spread_setting_strap;
   wire          lf_eff     = reg_mode ? ctrl_q[CTRL_LF] : lf_pin;
   wire          idle_eff   = reg_mode ? ctrl_q[CTRL_IDLE] : idle_select_strap;
   wire          grp_b      = (spread_eff >= SPREAD_SPLIT);
   wire [11:0]   div_sel    = lf_eff ? (grp_b ? DIV_LF_B : DIV_LF_A)
                                     : (grp_b ? DIV_HI_B : DIV_HI_A);
   wire          wr_ctrl    = reg_wr && (reg_addr == ADDR_CTRL);
   wire [7:0]    status     = {3'h0, st_q == DS_PDOWN, checking_q, st_q == DS_SLEEP,
                               pass_q, lock_q};
   wire [7:0]    rd_mux     = (reg_addr == ADDR_CTRL)   ? ctrl_q   :
                              (reg_addr == ADDR_STATUS) ? status   :
                              (reg_addr == ADDR_ERRCNT) ? errcnt_q : 8'h00;

   dltpc_prbs7 #(.WIDTH(PAYLOAD_W)) u_chk (
      .state      (chk_state_q),
      .bits       (expect_bits),
      .next_state (chk_next)
   );

   // a bit changes once the second and third stages agree
   assign pin_f_d = (pin_s2_q & ~(pin_s2_q ^ pin_s3_q)) | (pin_f_q & (pin_s2_q ^ pin_s3_q));

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pin_s1_q <= 3'h1;
         pin_s2_q <= 3'h1;
         pin_s3_q <= 3'h1;
         pin_f_q  <= 3'h1;
      end else begin
         pin_s1_q <= {link.low_freq_range_select, link.self_test_enable, link.power_enable_n};
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
         pin_f_q  <= pin_f_d;
      end
   end

   // link state: power-down, sleep, acquisition, lock
   always_comb begin
      st_d = st_q;
      case (st_q)
         DS_PDOWN: begin
            if (!(auto_detect_strap && mark_none)) begin
               st_d = DS_ACQUIRE;
            end
         end
         DS_SLEEP: begin
            if (!mark_none) begin
               st_d = DS_ACQUIRE;
            end
         end
         DS_ACQUIRE: begin
            if (stop_now) begin
               st_d = auto_detect_strap ? DS_PDOWN : DS_SLEEP;
            end else if (mark_good && good_cnt_q == LOCK_GOOD_FRAMES - 3'h1) begin
               st_d = DS_LOCKED;
            end
         end
         DS_LOCKED: begin
            if (!mark_good) begin
               st_d = DS_ACQUIRE;
            end
         end
         default: st_d = DS_PDOWN;
      endcase
      if (pd_pin) begin
         st_d = DS_PDOWN;
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         st_q       <= DS_PDOWN;
         good_cnt_q <= '0;
         stop_cnt_q <= '0;
         lock_q     <= 1'b0;
      end else begin
         st_q       <= st_d;
         good_cnt_q <= (mark_good && st_q == DS_ACQUIRE) ? good_cnt_q + 3'h1 : 3'h0;
         stop_cnt_q <= (mark_none && !stop_now) ? stop_cnt_q + 4'h1 : 4'h0;
         lock_q     <= (st_d == DS_LOCKED);
      end
   end

   // registers: cleared in power-down, kept through sleep
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q      <= CTRL_RESET;
         reg_rdata_q <= 8'h00;
      end else begin
         if (st_q == DS_PDOWN) begin
            ctrl_q <= CTRL_RESET;
         end else if (wr_ctrl) begin
            ctrl_q <= reg_wdata;
         end
         reg_rdata_q <= reg_rd ? rd_mux : 8'h00;
      end
   end

   // self-test checker and pass pin
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         test_pin_d1_q <= 1'b0;
         checking_q    <= 1'b0;
         chk_state_q   <= PRBS_SEED;
         chk_sync_q    <= 1'b0;
         err_seen_q    <= 1'b0;
         errcnt_q      <= 8'h00;
         pass_q        <= 1'b1;
      end else if (st_q == DS_PDOWN) begin
         test_pin_d1_q <= 1'b0;
         checking_q    <= 1'b0;
         chk_sync_q    <= 1'b0;
         err_seen_q    <= 1'b0;
         errcnt_q      <= 8'h00;
         pass_q        <= 1'b1;
      end else begin
         test_pin_d1_q <= test_pin;
         if (test_start) begin
            checking_q <= 1'b1;
            chk_sync_q <= 1'b0;
            err_seen_q <= 1'b0;
            errcnt_q   <= 8'h00;
            pass_q     <= 1'b1;
         end else if (test_stop) begin
            checking_q <= 1'b0;
            pass_q     <= ~err_seen_q;
         end else if (check_on) begin
            if (!chk_sync_q) begin
               chk_state_q <= link.payload[6:0];
               chk_sync_q  <= 1'b1;
               pass_q      <= 1'b1;
            end else begin
               chk_state_q <= chk_next;
               pass_q      <= ~mismatch;
               if (mismatch) begin
                  err_seen_q <= 1'b1;
                  errcnt_q   <= (errcnt_q == 8'hff) ? errcnt_q : errcnt_q + 8'h01;
               end
            end
         end
      end
   end

   // parallel outputs and idle states
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         data_out_q   <= '0;
         data_oe_q    <= 1'b0;
         clk_out_en_q <= 1'b0;
      end else if (st_q == DS_PDOWN || st_q == DS_SLEEP) begin
         data_out_q   <= '0;
         data_oe_q    <= idle_eff;
         clk_out_en_q <= idle_eff;
      end else if (locked && !link.test_cmd) begin
         data_out_q   <= link.payload;
         data_oe_q    <= 1'b1;
         clk_out_en_q <= 1'b1;
      end else begin
         data_out_q   <= '0;
         data_oe_q    <= 1'b0;
         clk_out_en_q <= 1'b0;
      end
   end

   // spread clock generator settings, applied to clock and data alike
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         spread_enable_q  <= 1'b0;
         spread_divisor_q <= 12'h000;
         spread_dev_q     <= 5'h00;
      end else begin
         spread_enable_q  <= (spread_eff != 3'h0) && (st_q == DS_LOCKED);
         spread_divisor_q <= (spread_eff != 3'h0) ? div_sel : 12'h000;
         spread_dev_q     <= DEV_TABLE[{lf_eff, spread_eff}];
      end
   end
endmodule

// file: dltpc_pkg.sv
package dltpc_pkg;

   // link framing
   localparam int          PAYLOAD_W        = 24;          // payload bits per frame
   localparam logic [1:0]  MARK_GOOD        = 2'h2;        // marker bit1 high, bit0 low
   localparam logic [1:0]  MARK_NONE        = 2'h0;        // no embedded clock bits
   localparam logic [2:0]  LOCK_GOOD_FRAMES = 3'h4;        // good frames needed for lock
   localparam logic [3:0]  STOP_FRAMES      = 4'h8;        // empty frames meaning stop
   localparam logic [4:0]  TEST_LEAD_CYCLES = 5'h10;       // ser test ahead of des test
   localparam logic [6:0]  PRBS_SEED        = 7'h7f;       // generator reset value
   localparam logic [5:0]  LF_LIMIT_MHZ     = 6'h14;       // 20 mhz range boundary

   // control/status registers of the deserializer
   localparam logic [7:0]  ADDR_CTRL        = 8'h00;
   localparam logic [7:0]  ADDR_STATUS      = 8'h01;
   localparam logic [7:0]  ADDR_ERRCNT      = 8'h02;
   localparam logic [7:0]  CTRL_RESET       = 8'h00;
   localparam int          CTRL_REG_MODE    = 0;           // 1: settings from register
   localparam int          CTRL_SPREAD_LSB  = 1;           // spread_setting field [3:1]
   localparam int          CTRL_LF          = 4;           // low_freq_range_setting
   localparam int          CTRL_IDLE        = 5;           // output_idle_state_select
   localparam int          ST_LOCK          = 0;
   localparam int          ST_PASS          = 1;
   localparam int          ST_SLEEP         = 2;
   localparam int          ST_TEST          = 3;
   localparam int          ST_PDOWN         = 4;

   // spread clock generator decode
   localparam logic [11:0] DIV_HI_A         = 12'h878;     // clk/2168
   localparam logic [11:0] DIV_HI_B         = 12'h514;     // clk/1300
   localparam logic [11:0] DIV_LF_A         = 12'h271;     // clk/625
   localparam logic [11:0] DIV_LF_B         = 12'h181;     // clk/385
   localparam logic [2:0]  SPREAD_SPLIT     = 3'h5;        // first setting of group b
   // deviation in tenths of a percent, indexed by {range, setting}
   localparam logic [4:0]  DEV_TABLE [16]   = '{5'h00, 5'h09, 5'h0c, 5'h13, 5'h17, 5'h07,
                                                5'h0d, 5'h11, 5'h00, 5'h07, 5'h0d, 5'h12,
                                                5'h16, 5'h07, 5'h0c, 5'h11};

   // deserializer link states
   typedef enum logic [1:0] {DS_PDOWN, DS_SLEEP, DS_ACQUIRE, DS_LOCKED} dltpc_state_t;

endpackage

// file: dltpc_link_if.sv
`timescale 1ns/1ps
interface dltpc_link_if;
   import dltpc_pkg::*;
   logic [PAYLOAD_W-1:0] payload;              // frame payload
   logic [1:0]           marker;               // clock_marker_bit1, clock_marker_bit0
   logic                 test_cmd;             // self-test command carried in frame
   logic                 power_enable_n;       // host power control, low = power down
   logic                 self_test_enable;     // host drives deserializer test enable
   logic                 low_freq_range_select; // high for link clock below 20 mhz
   modport ser (output payload, marker, test_cmd, power_enable_n, self_test_enable,
                output low_freq_range_select);
   modport des (input payload, marker, test_cmd, power_enable_n, self_test_enable,
                input low_freq_range_select);
endinterface

// file: dltpc_prbs7.sv
`timescale 1ns/1ps
// one frame of x^7 + x^6 + 1; first bit in the msb, final state = last seven bits
module dltpc_prbs7
   import dltpc_pkg::*;
#(
   parameter int WIDTH = PAYLOAD_W
) (
   // state in
   input  wire logic [6:0]       state,
   // frame out
   output logic      [WIDTH-1:0] bits,
   output logic      [6:0]       next_state
);
   // step the register once per output bit
   always_comb begin
      logic [6:0] s;
      logic       nb;
      s    = state;
      nb   = 1'b0;
      bits = '0;
      for (int i = 0; i < WIDTH; i++) begin
         nb                = s[6] ^ s[5];
         bits[WIDTH-1-i]   = nb;
         s                 = {s[5:0], nb};
      end
      next_state = s;
   end
endmodule

// file: dltpc_ser_end.sv
`timescale 1ns/1ps
module dltpc_ser_end
   import dltpc_pkg::*;
(
   // clock and reset
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   // host side
   input  wire logic                 host_power_on,
   input  wire logic                 host_test_request,
   input  wire logic                 clock_running,
   input  wire logic [5:0]           link_freq_mhz,
   input  wire logic [PAYLOAD_W-1:0] data_in,
   // link side
   dltpc_link_if.ser                 link
);
   logic [6:0]           lfsr_q;          // generator state
   logic [6:0]           lfsr_next;       // state after this frame
   logic [PAYLOAD_W-1:0] prbs_bits;       // pattern for this frame
   logic                 ser_test_q;      // serializer in self-test
   logic                 des_test_q;      // deserializer enable driven
   logic [4:0]           lead_q;          // lead count before des enable
   logic [PAYLOAD_W-1:0] payload_q;
   logic [1:0]           marker_q;
   logic                 pwr_n_q;
   logic                 lf_q;

   dltpc_prbs7 #(.WIDTH(PAYLOAD_W)) u_gen (
      .state      (lfsr_q),
      .bits       (prbs_bits),
      .next_state (lfsr_next)
   );

   // test sequencing: serializer first, deserializer after the lead time
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ser_test_q <= 1'b0;
         des_test_q <= 1'b0;
         lead_q     <= '0;
      end else if (!host_test_request) begin
         ser_test_q <= 1'b0;
         des_test_q <= 1'b0;
         lead_q     <= '0;
      end else if (clock_running) begin
         ser_test_q <= 1'b1;
         if (lead_q == TEST_LEAD_CYCLES) begin
            des_test_q <= 1'b1;
         end else begin
            lead_q <= lead_q + 5'h01;
         end
      end
   end

   // frame building and control pins
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         lfsr_q    <= PRBS_SEED;
         payload_q <= '0;
         marker_q  <= MARK_NONE;
         pwr_n_q   <= 1'b1;
         lf_q      <= 1'b0;
      end else begin
         pwr_n_q  <= host_power_on;
         lf_q     <= (link_freq_mhz < LF_LIMIT_MHZ);
         marker_q <= clock_running ? MARK_GOOD : MARK_NONE;
         if (ser_test_q && clock_running) begin
            payload_q <= prbs_bits;
            lfsr_q    <= lfsr_next;
         end else begin
            payload_q <= data_in;
         end
      end
   end

   assign link.payload               = payload_q;
   assign link.marker                = marker_q;
   assign link.test_cmd              = ser_test_q;
   assign link.power_enable_n        = pwr_n_q;
   assign link.self_test_enable      = des_test_q;
   assign link.low_freq_range_select = lf_q;
endmodule

// file: dltpc_link_assertions.sv
`timescale 1ns/1ps
// watches the link between the two ends and the deserializer flags
module dltpc_link_assertions
   import dltpc_pkg::*;
(
   // clock and reset
   input  wire logic                 mclk,
   input  wire logic                 reset_n,
   // link signals
   input  wire logic [PAYLOAD_W-1:0] payload,
   input  wire logic [1:0]           marker,
   input  wire logic                 test_cmd,
   input  wire logic                 power_enable_n,
   input  wire logic                 self_test_enable,
   // deserializer flags
   input  wire logic                 lock_q,
   input  wire logic                 pass_q,
   input  wire logic                 data_oe_q
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);

   wire logic [6:0] tail = payload[6:0];       // generator state after a frame

   // next frame of x^7 + x^6 + 1, first bit in the msb
   function automatic logic [PAYLOAD_W-1:0] frame_of(logic [6:0] s);
      for (int i = PAYLOAD_W - 1; i >= 0; i--) begin
         s = {s[5:0], s[6] ^ s[5]};
         frame_of[i] = s[0];
      end
   endfunction

   a_enable_late: assert property ($rose(self_test_enable) |-> $past(test_cmd, 16))
      else $error("des test enable raised too soon");
   a_enable_with_cmd: assert property (self_test_enable |-> test_cmd)
      else $error("des test enable without ser test");
   a_prbs_frames: assert property (test_cmd && $past(test_cmd) && $past(test_cmd, 2)
      |-> payload == frame_of($past(tail))) else $error("test payload off sequence");
   a_lock_drop: assert property (marker != MARK_GOOD |-> ##[1:2] !lock_q)
      else $error("lock kept after bad marker");
   a_lock_acquire: assert property ($rose(lock_q) |-> $past(marker, 2) == MARK_GOOD
      && $past(marker, 3) == MARK_GOOD && $past(marker, 4) == MARK_GOOD)
      else $error("lock before good frames");
   a_sleep_no_lock: assert property ((marker == MARK_NONE) [*8] |=> !lock_q)
      else $error("lock during stopped stream");
   a_pdown_flags: assert property (!power_enable_n [*8] |-> !lock_q && pass_q)
      else $error("flags wrong in power-down");
   a_test_outputs_off: assert property (test_cmd [*8] |-> !data_oe_q)
      else $error("outputs driven during test");
   a_clean_pass: assert property ($fell(self_test_enable) |-> ##6 pass_q [*3])
      else $error("clean test not latched high");
endmodule

// file: test_deser_link_test_power_ctrl.sv
`timescale 1ns/1ps
// both ends back to back on one link; a second link is driven by the bench
module test_deser_link_test_power_ctrl;
   import dltpc_pkg::*;
   // clock, reset and host pins
   logic                 mclk, reset_n, host_power_on, host_test_request, clock_running;
   logic [5:0]           link_freq_mhz;
   logic [PAYLOAD_W-1:0] data_in, dout_a, frm;
   // straps and register port
   logic [2:0]           spread_setting_strap, s;
   logic                 idle_select_strap, auto_detect_strap, reg_wr, reg_rd, rd_prev;
   logic [7:0]           reg_addr, reg_wdata, rdata_a, rdata_b;
   // deserializer outputs
   logic                 oe_a, lock_a, pass_a, lock_b, pass_b, sp_en, lf, count_on, clk_en_a;
   logic [11:0]          sp_div, div;
   logic [4:0]           sp_dev;
   logic [4:0]           devs [16] = '{5'h00, 5'h09, 5'h0c, 5'h13, 5'h17, 5'h07, 5'h0d, 5'h11,
                                       5'h00, 5'h07, 5'h0d, 5'h12, 5'h16, 5'h07, 5'h0c, 5'h11};
   logic [8:0]           exp_q [$];            // {instance, expected read data}
   logic [8:0]           note;
   logic [31:0]          lfsr = 32'h3b22d004;  // random source
   logic [6:0]           gen_s;                // bench pattern generator
   int                   miscompares, n_checks, cycles, pulses;

   dltpc_link_if link_a ();
   dltpc_link_if link_b ();
   dltpc_ser_end u_dltpc_ser_end (.mclk, .reset_n, .host_power_on, .host_test_request,
      .clock_running, .link_freq_mhz, .data_in, .link(link_a));
   dltpc_deser_end u_dltpc_deser_end (.mclk, .reset_n, .link(link_a), .spread_setting_strap,
      .idle_select_strap, .auto_detect_strap, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_q(rdata_a), .data_out_q(dout_a), .data_oe_q(oe_a), .clk_out_en_q(clk_en_a),
      .lock_q(lock_a), .pass_q(pass_a), .spread_enable_q(sp_en), .spread_divisor_q(sp_div),
      .spread_dev_q(sp_dev));
   dltpc_deser_end u_dltpc_deser_end_b (.mclk, .reset_n, .link(link_b), .spread_setting_strap,
      .idle_select_strap, .auto_detect_strap, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata_q(rdata_b), .data_out_q(), .data_oe_q(), .clk_out_en_q(), .lock_q(lock_b),
      .pass_q(pass_b), .spread_enable_q(), .spread_divisor_q(), .spread_dev_q());
   dltpc_link_assertions u_dltpc_link_assertions (.mclk, .reset_n, .payload(link_a.payload),
      .marker(link_a.marker), .test_cmd(link_a.test_cmd), .power_enable_n(link_a.power_enable_n),
      .self_test_enable(link_a.self_test_enable), .lock_q(lock_a), .pass_q(pass_a),
      .data_oe_q(oe_a));

   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;

   function automatic logic [31:0] lfsr_next(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   // x^7 + x^6 + 1 frame, first bit in the msb
   function automatic logic [PAYLOAD_W-1:0] prbs_frame(logic [6:0] st);
      for (int i = PAYLOAD_W - 1; i >= 0; i--) begin
         st = {st[5:0], st[6] ^ st[5]};
         prbs_frame[i] = st[0];
      end
   endfunction

   task automatic conclude();
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // compare an output level
   task automatic chk_out(logic [31:0] got, logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // compare read data
   task automatic chk_reg(logic [7:0] got, logic [7:0] exp);
      chk_out({24'h0, got}, {24'h0, exp});
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge mclk);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge mclk);
      reg_wr    <= 1'b0;
   endtask
   // read strobe; the note waits in the queue for the monitor
   task automatic rd(logic sel, logic [7:0] a, logic [7:0] e);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      exp_q.push_back({sel, e});
      @(posedge mclk);
      reg_rd   <= 1'b0;
   endtask
   // bounded wait for lock on one instance
   task automatic wait_lock(logic sel);
      for (int i = 0; i < 80 && (sel ? lock_b : lock_a) !== 1'b1; i++) @(posedge mclk);
      chk_out(sel ? lock_b : lock_a, 1);
   endtask

   // read data stand the cycle after the strobe; also counts pass pulses and the timeout
   always @(posedge mclk) begin
      rd_prev <= reg_rd;
      if (rd_prev) begin
         note = exp_q.pop_front();
         chk_reg(note[8] ? rdata_b : rdata_a, note[7:0]);
      end
      if (count_on && pass_b === 1'b0) pulses++;
      cycles++;
      if (cycles == 5000) begin
         miscompares++;
         conclude();
      end
   end

   initial begin
      {host_power_on, host_test_request, clock_running, reg_wr, reg_rd, rd_prev} = '0;
      {idle_select_strap, auto_detect_strap, count_on, reset_n} = '0;
      link_freq_mhz = 6'h28;
      data_in = '0;
      spread_setting_strap = 3'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      link_b.payload = '0;
      link_b.marker = MARK_NONE;
      {link_b.test_cmd, link_b.self_test_enable, link_b.low_freq_range_select} = '0;
      link_b.power_enable_n = 1'b1;
      repeat (10) @(posedge mclk);
      reset_n <= 1'b1;
      // the power-down level needs four edges through the pin synchroniser
      repeat (8) @(posedge mclk);
      rd(0, ADDR_STATUS, 8'h12);
      wr(ADDR_CTRL, 8'h3f);
      rd(0, ADDR_CTRL, 8'h00);
      rd(0, 8'h07, 8'h00);
      chk_out(oe_a, 0);
      $display("test power-down done");
      host_power_on <= 1'b1;
      clock_running <= 1'b1;
      data_in <= lfsr[23:0];
      wait_lock(0);
      rd(0, ADDR_STATUS, 8'h03);
      for (int i = 0; i < 16; i++) begin
         wr(ADDR_CTRL, {3'h0, i[3], i[2:0], 1'b1});
         repeat (3) @(posedge mclk);
         s = i[2:0];
         div = s < SPREAD_SPLIT ? (i[3] ? 12'h271 : 12'h878) : (i[3] ? 12'h181 : 12'h514);
         chk_out(sp_div, s == 3'h0 ? 12'h000 : div);
         chk_out(sp_dev, devs[i]);
         chk_out(sp_en, s != 3'h0);
      end
      wr(ADDR_CTRL, 8'h00);
      spread_setting_strap <= 3'h3;
      for (int i = 0; i < 4; i++) begin
         lfsr = lfsr_next(lfsr);
         link_freq_mhz <= 6'h05 + 6'(lfsr % 46);
         data_in <= lfsr[23:0];
         repeat (10) @(posedge mclk);
         lf = link_freq_mhz < LF_LIMIT_MHZ;
         chk_out(sp_div, lf ? 12'h271 : 12'h878);
         chk_out(sp_dev, devs[{lf, 3'h3}]);
         chk_out(dout_a, data_in);
      end
      $display("test spread decode done");
      wr(ADDR_CTRL, 8'h2b);
      clock_running <= 1'b0;
      repeat (24) @(posedge mclk);
      rd(0, ADDR_STATUS, 8'h06);
      rd(0, ADDR_CTRL, 8'h2b);
      chk_out(oe_a, 1);
      chk_out(dout_a, 0);
      chk_out(clk_en_a, 1);
      chk_out(sp_en, 0);
      clock_running <= 1'b1;
      wait_lock(0);
      $display("test sleep done");
      host_test_request <= 1'b1;
      repeat (40) @(posedge mclk);
      chk_out(oe_a, 0);
      chk_out(clk_en_a, 0);
      rd(0, ADDR_STATUS, 8'h0b);
      host_test_request <= 1'b0;
      repeat (12) @(posedge mclk);
      rd(0, ADDR_STATUS, 8'h03);
      rd(0, ADDR_ERRCNT, 8'h00);
      chk_out(oe_a, 1);
      $display("test clean self-test done");
      gen_s = PRBS_SEED;
      for (int f = 0; f < 70; f++) begin
         @(posedge mclk);
         frm = prbs_frame(gen_s);
         gen_s = frm[6:0];
         count_on <= f >= 20 && f < 58;
         link_b.marker <= MARK_GOOD;
         link_b.test_cmd <= f < 64;
         link_b.self_test_enable <= f >= 20 && f < 56;
         link_b.payload <= frm ^ {f == 34 || f == 40 || f == 46, 23'h0};
      end
      chk_out(pulses, 3);
      chk_out(pass_b, 0);
      rd(1, ADDR_ERRCNT, 8'h03);
      rd(1, ADDR_STATUS, 8'h01);
      link_b.marker <= 2'h1;
      @(posedge mclk);
      link_b.marker <= MARK_GOOD;
      repeat (2) @(posedge mclk);
      chk_out(lock_b, 0);
      chk_out(pass_b, 0);
      auto_detect_strap <= 1'b1;
      link_b.marker <= MARK_NONE;
      repeat (14) @(posedge mclk);
      rd(1, ADDR_STATUS, 8'h12);
      rd(1, ADDR_CTRL, 8'h00);
      link_b.marker <= MARK_GOOD;
      wait_lock(1);
      $display("test errored self-test done");
      repeat (3) @(posedge mclk);
      conclude();
   end
endmodule
